// ==== seec_top.sv ====
// two-wire serial eeprom slave with ident page lock, read acknowledge and group ecc
// Notes on behaviour
// - ident page write data byte is acked when page unlocked and write protect low, not acked when locked.
// - a start inside an unfinished command resets sequencing and drops the pending command.
// - a stop that triggers no write returns the device to standby.
// - in reads the device releases the data line and samples the ninth bit.
// - master leaving the ninth bit high ends the read and enters standby.
// - while power-on reset holds, all bus activity is ignored.
// - after power-on reset the device is in standby and deselected.
// - main array data is guarded by a code over each four-byte group; ident page bytes carry no code.
// - one bad bit in a group is corrected before it goes on the bus.
// - a byte write reprograms its whole group, other three bytes unchanged.
// - a group is four bytes sharing all address bits above the lowest two.
// - as delivered every main array byte reads all ones.
// - as delivered the first three ident page bytes hold the ident code.
// - ident page commands carry device type 1011b in the select byte.
// - a locked ident page acks no write data and stays unchanged.
`timescale 1ns/1ps
module seec_top #(
    parameter int unsigned WRITE_CYCLES = seec_pkg::WRITE_CYC,
    parameter logic [23:0] IDENT_CODE = seec_pkg::IDENT_CODE_DEF // arbitrary value
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic [2:0] i_chip_enable,
    input wire logic i_write_protect_input
);
    typedef struct packed {
        seec_pkg::seec_state_e st;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic [2:0] ce_m;
        logic [2:0] ce_s;
        logic wp_m;
        logic wp_s;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [1:0] idx;
        logic is_id;
        logic is_rd;
        logic mack;
        logic slot10;
        logic sda_oe;
        logic sda_out;
        logic [15:0] addr;
        logic pend_v;
        logic pend_id;
        logic pend_lock;
        logic [15:0] pend_addr;
        logic [7:0] pend_data;
        logic locked;
        logic [19:0] wcnt;
    } seec_reg_s;

    seec_reg_s q;
    seec_reg_s d;

    logic [37:0] main_mem [0:seec_pkg::GRP_WORDS-1];
    logic [7:0] id_mem [0:seec_pkg::IDPG_BYTES-1];

    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic mem_we;
    logic id_we;
    logic [13:0] rd_grp;
    logic [37:0] rd_word;
    logic [31:0] rd_fixed;
    logic [31:0] wr_data;
    logic [5:0] wr_chk;
    logic [7:0] rd_byte;
    logic [19:0] wlast;

    assign wlast = 20'(WRITE_CYCLES - 1);
    // edges are taken only from the second synchroniser stage and its delayed copy
    assign rise = q.scl_s & ~q.scl_p;
    assign fall = ~q.scl_s & q.scl_p;
    assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign stop_c = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

    // a write cycle reads its own group so the three other bytes are carried along
    assign rd_grp = (q.st == seec_pkg::ST_WRITE) ? q.pend_addr[15:2] : q.addr[15:2];
    assign rd_word = main_mem[rd_grp];

    seec_ecc u_ecc (
        .i_rd_word(rd_word),
        .i_wr_data(wr_data),
        .o_rd_fixed(rd_fixed),
        .o_wr_chk(wr_chk)
    );

    always_comb begin
        wr_data = rd_fixed;
        wr_data[{q.pend_addr[1:0], 3'h0} +: 8] = q.pend_data;
        if (q.is_id) begin
            rd_byte = id_mem[q.addr[6:0]];
        end else begin
            rd_byte = rd_fixed[{q.addr[1:0], 3'h0} +: 8];
        end
    end

    always_comb begin
        logic ack;
        logic lock_cmd;
        ack = 1'b0;
        lock_cmd = 1'b0;
        d = q;
        mem_we = 1'b0;
        id_we = 1'b0;
        d.scl_m = i_scl;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = i_sda;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.ce_m = i_chip_enable;
        d.ce_s = q.ce_m;
        d.wp_m = i_write_protect_input;
        d.wp_s = q.wp_m;
        case (q.st)
            seec_pkg::ST_WRITE: begin
                // the bus is not watched at all while the cell array is being programmed
                if (q.wcnt == '0) begin
                    if (q.pend_lock) begin
                        d.locked = 1'b1;
                    end else if (q.pend_id) begin
                        id_we = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                    end
                end
                d.wcnt = q.wcnt + 20'h00001;
                if (q.wcnt >= wlast) begin
                    d.st = seec_pkg::ST_IDLE;
                    d.pend_v = 1'b0;
                end
            end
            default: begin
                if (start_c) begin
                    d.st = seec_pkg::ST_RX;
                    d.bitcnt = '0;
                    d.idx = seec_pkg::IDX_SEL;
                    d.pend_v = 1'b0;
                    d.pend_lock = 1'b0;
                    d.slot10 = 1'b0;
                    d.mack = 1'b0;
                    d.sda_oe = 1'b0;
                end else if (stop_c) begin
                    d.sda_oe = 1'b0;
                    d.slot10 = 1'b0;
                    if (q.slot10 && q.pend_v) begin
                        d.st = seec_pkg::ST_WRITE;
                        d.wcnt = '0;
                    end else begin
                        d.st = seec_pkg::ST_IDLE;
                    end
                end else begin
                    case (q.st)
                        seec_pkg::ST_RX: begin
                            if (rise) begin
                                d.shreg = {q.shreg[6:0], q.sda_s};
                                d.bitcnt = q.bitcnt + 4'h1;
                                d.slot10 = q.slot10 && q.bitcnt == 4'h0;
                            end else if (fall && q.bitcnt == seec_pkg::BIT_LAST) begin
                                if (q.idx == seec_pkg::IDX_SEL) begin
                                    ack = (q.shreg[7:4] == seec_pkg::DEV_MAIN
                                        || q.shreg[7:4] == seec_pkg::DEV_IDENT)
                                        && q.shreg[3:1] == q.ce_s;
                                    d.is_id = (q.shreg[7:4] == seec_pkg::DEV_IDENT);
                                    d.is_rd = q.shreg[0];
                                    d.idx = seec_pkg::IDX_AHI;
                                end else if (q.idx == seec_pkg::IDX_AHI) begin
                                    ack = 1'b1;
                                    d.addr[15:8] = q.shreg;
                                    d.idx = seec_pkg::IDX_ALO;
                                end else if (q.idx == seec_pkg::IDX_ALO) begin
                                    ack = 1'b1;
                                    d.addr[7:0] = q.shreg;
                                    d.idx = seec_pkg::IDX_DATA;
                                end else begin
                                    lock_cmd = q.is_id && q.addr[seec_pkg::PAGE_SEL_BIT];
                                    if (q.is_id) begin
                                        ack = ~q.locked & ~q.wp_s;
                                    end else begin
                                        ack = ~q.wp_s;
                                    end
                                    if (ack) begin
                                        // only the last byte of a burst is kept pending
                                        d.pend_v = ~lock_cmd | q.shreg[seec_pkg::LOCK_BIT];
                                        d.pend_id = q.is_id;
                                        d.pend_lock = lock_cmd;
                                        d.pend_addr = q.addr;
                                        d.pend_data = q.shreg;
                                        d.slot10 = 1'b1;
                                        d.addr[6:0] = q.addr[6:0] + 7'h01;
                                    end
                                end
                                if (ack) begin
                                    d.st = seec_pkg::ST_ACKTX;
                                    d.sda_oe = 1'b1;
                                end else begin
                                    d.st = seec_pkg::ST_IDLE;
                                    d.sda_oe = 1'b0;
                                end
                            end
                        end
                        seec_pkg::ST_ACKTX: begin
                            if (fall) begin
                                d.bitcnt = '0;
                                if (q.is_rd) begin
                                    d.st = seec_pkg::ST_TX;
                                    d.shreg = rd_byte;
                                    d.sda_oe = ~rd_byte[7];
                                    d.bitcnt = seec_pkg::BIT_FIRST;
                                end else begin
                                    d.st = seec_pkg::ST_RX;
                                    d.sda_oe = 1'b0;
                                end
                            end
                        end
                        seec_pkg::ST_TX: begin
                            if (fall) begin
                                if (q.bitcnt == seec_pkg::BIT_LAST) begin
                                    d.sda_oe = 1'b0;
                                    d.st = seec_pkg::ST_ACKRX;
                                    d.mack = 1'b0;
                                    if (q.is_id) begin
                                        d.addr[6:0] = q.addr[6:0] + 7'h01;
                                    end else begin
                                        d.addr = q.addr + 16'h0001;
                                    end
                                end else begin
                                    d.shreg = {q.shreg[6:0], 1'b0};
                                    d.sda_oe = ~q.shreg[6];
                                    d.bitcnt = q.bitcnt + 4'h1;
                                end
                            end
                        end
                        seec_pkg::ST_ACKRX: begin
                            if (rise) begin
                                if (q.sda_s) begin
                                    d.st = seec_pkg::ST_IDLE;
                                end else begin
                                    d.mack = 1'b1;
                                end
                            end else if (fall && q.mack) begin
                                d.st = seec_pkg::ST_TX;
                                d.mack = 1'b0;
                                d.shreg = rd_byte;
                                d.sda_oe = ~rd_byte[7];
                                d.bitcnt = seec_pkg::BIT_FIRST;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            q <= '0;
            q.st <= seec_pkg::ST_IDLE;
            // idle bus is high; starting the synchronisers high avoids a false start
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (mem_we) begin
            main_mem[q.pend_addr[15:2]] <= {wr_chk, wr_data};
        end
        if (id_we) begin
            id_mem[q.pend_addr[6:0]] <= q.pend_data;
        end
    end

    // array contents model the delivered part and are not touched by reset
    initial begin
        for (int i = 0; i < seec_pkg::GRP_WORDS; i++) begin
            main_mem[i] = {seec_pkg::chk_of(seec_pkg::ERASED_WORD), seec_pkg::ERASED_WORD};
        end
        for (int j = 0; j < seec_pkg::IDPG_BYTES; j++) begin
            id_mem[j] = seec_pkg::ERASED_BYTE;
        end
        id_mem[0] = IDENT_CODE[23:16];
        id_mem[1] = IDENT_CODE[15:8];
        id_mem[2] = IDENT_CODE[7:0];
    end

    assign o_sda_oe = q.sda_oe;
    assign o_sda_out = q.sda_out;

    start_discard_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (q.st != seec_pkg::ST_WRITE && start_c) |=> (q.st == seec_pkg::ST_RX && !q.pend_v))
        else $error("start did not reset sequencing");
    stop_standby_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (q.st != seec_pkg::ST_WRITE && !start_c && stop_c && !(q.slot10 && q.pend_v))
        |=> q.st == seec_pkg::ST_IDLE ##1 !o_sda_oe)
        else $error("stop did not return to standby");
    read_release_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (q.st == seec_pkg::ST_TX && fall && q.bitcnt == seec_pkg::BIT_LAST)
        |=> (q.st == seec_pkg::ST_ACKRX && !o_sda_oe) [*2])
        else $error("data line not released for master ack");
    read_nack_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (q.st == seec_pkg::ST_ACKRX && rise && q.sda_s && !start_c && !stop_c)
        |=> (q.st == seec_pkg::ST_IDLE && !o_sda_oe))
        else $error("read not ended on master nack");
    por_quiet_a: assert property (@(posedge i_sys_clk)
        i_rst |=> (q.st == seec_pkg::ST_IDLE && !o_sda_oe && !q.pend_v))
        else $error("device active during power-on reset");
    ident_ack_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (q.st == seec_pkg::ST_RX && fall && q.bitcnt == seec_pkg::BIT_LAST && !start_c
        && !stop_c && q.idx == seec_pkg::IDX_DATA && q.is_id)
        |=> (o_sda_oe == ($past(!q.locked) && $past(!q.wp_s))))
        else $error("ident page data ack does not follow lock state");
    ident_guard_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        id_we |-> (!q.locked && q.pend_id && !q.pend_lock))
        else $error("locked ident page written");
    group_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        mem_we |-> (((wr_data ^ rd_fixed) & ~(32'h000000ff << {q.pend_addr[1:0], 3'h0})) == '0
        && rd_grp == q.pend_addr[15:2]))
        else $error("group rewrite changed a neighbour byte");
    write_trigger_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (q.st == seec_pkg::ST_RX && !start_c && stop_c && !(q.slot10 && q.pend_v))
        |=> (q.st != seec_pkg::ST_WRITE && $stable(q.locked)))
        else $error("write cycle started without a tenth-slot stop");
endmodule // seec_top

// ==== seec_pkg.sv ====
// shared constants, state enum and check-bit functions for the serial eeprom slave
package seec_pkg;
    localparam logic [3:0] DEV_MAIN = 4'ha;
    localparam logic [3:0] DEV_IDENT = 4'hb;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [1:0] IDX_SEL = 2'h0;
    localparam logic [1:0] IDX_AHI = 2'h1;
    localparam logic [1:0] IDX_ALO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;
    localparam int ADDR_W = 16;
    localparam int GRP_W = 14;
    localparam int GRP_WORDS = 16384;
    localparam int DATA_W = 32;
    localparam int CHK_W = 6;
    localparam int CODE_LAST = 38;
    localparam int IDPG_W = 7;
    localparam int IDPG_BYTES = 128;
    localparam int PAGE_SEL_BIT = 10;
    localparam int LOCK_BIT = 1;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [31:0] ERASED_WORD = 32'hffffffff;
    localparam logic [23:0] IDENT_CODE_DEF = 24'h5a3c81;
    localparam int WCNT_W = 20;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned T_WRITE_NS = 4000000;
    localparam int unsigned WRITE_CYC = T_WRITE_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACKTX,
        ST_TX,
        ST_ACKRX,
        ST_WRITE
    } seec_state_e;

    // code position of data bit k: skips the power-of-two slots held by check bits
    function automatic logic [5:0] dpos(input int k);
        int c;
        logic [5:0] r;
        c = 0;
        r = '0;
        for (int p = 3; p <= CODE_LAST; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (c == k) begin
                    r = 6'(p);
                end
                c++;
            end
        end
        return r;
    endfunction

    function automatic logic [5:0] chk_of(input logic [31:0] d);
        logic [5:0] c;
        c = '0;
        for (int k = 0; k < DATA_W; k++) begin
            if (d[k]) begin
                c = c ^ dpos(k);
            end
        end
        return c;
    endfunction
endpackage

// ==== seec_ecc.sv ====
// single-error-correcting code over one four-byte group: correct on read, encode on write
`timescale 1ns/1ps
module seec_ecc (
    input wire logic [37:0] i_rd_word,
    input wire logic [31:0] i_wr_data,
    output logic [31:0] o_rd_fixed,
    output logic [5:0] o_wr_chk
);
    logic [5:0] syn;

    // syndrome equals the code position of a single flipped bit
    assign syn = seec_pkg::chk_of(i_rd_word[31:0]) ^ i_rd_word[37:32];
    assign o_wr_chk = seec_pkg::chk_of(i_wr_data);

    genvar g;
    generate
        for (g = 0; g < seec_pkg::DATA_W; g++) begin : g_fix
            assign o_rd_fixed[g] = i_rd_word[g] ^ (syn == seec_pkg::dpos(g));
        end
    endgenerate
endmodule // seec_ecc

// ==== seec_master.sv ====
// two-wire bus master model that faces the serial eeprom slave
`timescale 1ns/1ps
module seec_master (
    input wire logic i_sys_clk,
    input wire logic i_sda_wire,
    output logic o_scl,
    output logic o_sda
);
    // scl stands high between frames, sda released to the pull-up
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    // 32 clocks a bit: data moves mid low phase, wire sampled just before scl falls
    task automatic put_bit(input logic b, output logic r);
        tick(8);
        o_sda = b;
        tick(8);
        o_scl = 1'b1;
        tick(16);
        r = i_sda_wire;
        o_scl = 1'b0;
    endtask

    task automatic start();
        tick(8);
        o_sda = 1'b1;
        tick(8);
        o_scl = 1'b1;
        tick(8);
        o_sda = 1'b0;
        tick(8);
        o_scl = 1'b0;
    endtask

    task automatic stop();
        tick(8);
        o_sda = 1'b0;
        tick(8);
        o_scl = 1'b1;
        tick(8);
        o_sda = 1'b1;
        tick(8);
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask

    // last byte: sda left high in the ninth slot to end the read
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(last, r);
    endtask
endmodule // seec_master

// ==== seec_top_test.sv ====
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ps
module seec_top_test;
    localparam int WR_CYC = 20;
    localparam logic [2:0] CE = 3'h5;
    localparam logic [23:0] ID = 24'h3c96e1; // arbitrary value
    localparam logic [3:0] MN = seec_pkg::DEV_MAIN;
    localparam logic [3:0] IDP = seec_pkg::DEV_IDENT;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wp = 1'b0;
    logic scl;
    logic sda_m;
    logic o_sda_out;
    logic o_sda_oe;
    wire logic sda_wire = o_sda_oe ? (sda_m & o_sda_out) : sda_m;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic a;

    seec_top #(.WRITE_CYCLES(WR_CYC), .IDENT_CODE(ID)) dut (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_scl(scl),
        .i_sda(sda_wire),
        .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe),
        .i_chip_enable(CE),
        .i_write_protect_input(wp)
    );
    seec_master m (
        .i_sys_clk(i_sys_clk),
        .i_sda_wire(sda_wire),
        .o_scl(scl),
        .o_sda(sda_m)
    );

    initial begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic close_out();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // whole run needs some 40k clocks
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic addr_cmd(input logic [3:0] ty, input logic [15:0] ad, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        m.start();
        m.send({ty, CE, 1'b0}, a0);
        m.send(ad[15:8], a1);
        m.send(ad[7:0], a2);
        ok = a0 & a1 & a2;
    endtask

    task automatic write_byte(input logic [3:0] ty, input logic [15:0] ad,
                              input logic [7:0] d, output logic ack);
        logic ok;
        addr_cmd(ty, ad, ok);
        m.send(d, ack);
        m.stop();
        m.tick(2 * WR_CYC);
    endtask

    task automatic read4(input logic [3:0] ty, input logic [15:0] ad, input logic [31:0] exp);
        logic ok;
        logic r;
        logic idle;
        logic [7:0] d;
        addr_cmd(ty, ad, ok);
        check({7'h0, ok}, 8'h01);
        m.start();
        m.send({ty, CE, 1'b1}, ok);
        check({7'h0, ok}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            m.recv(k == 3, d);
            check(d, exp[31 - 8 * k -: 8]);
        end
        // after a refused acknowledge the slave must leave the wire alone
        idle = 1'b1;
        for (int k = 0; k < 9; k++) begin
            m.put_bit(1'b1, r);
            idle = idle & r;
        end
        check({7'h0, idle}, 8'h01);
        m.stop();
    endtask

    task automatic t_delivered();
        read4(MN, 16'hfffe, 32'hffffffff);
        read4(IDP, 16'h0000, {ID, 8'hff});
    endtask

    task automatic t_group();
        write_byte(MN, 16'h0105, 8'ha5, a);
        check({7'h0, a}, 8'h01);
        write_byte(MN, 16'h0106, 8'h3c, a);
        read4(MN, 16'h0104, 32'hffa53cff);
        read4(MN, 16'h0100, 32'hffffffff);
        wp = 1'b1;
        write_byte(MN, 16'h0107, 8'h5a, a);
        check({7'h0, a}, 8'h00);
        wp = 1'b0;
        // start in place of stop after a data byte must drop the write
        addr_cmd(MN, 16'h0104, a);
        m.send(8'h00, a);
        read4(MN, 16'h0104, 32'hffa53cff);
    endtask

    task automatic t_lockquery(input logic exp_ack);
        addr_cmd(IDP, 16'h0000, a);
        m.send(8'h77, a);
        check({7'h0, a}, {7'h0, exp_ack});
        m.start();
        m.stop();
        read4(IDP, 16'h0000, {ID, 8'hff});
    endtask

    task automatic t_lock();
        // unlocked ident write: upper address bits other than the page select are ignored
        write_byte(IDP, 16'h0385, 8'h42, a);
        check({7'h0, a}, 8'h01);
        read4(IDP, 16'h0004, 32'hff42ffff);
        write_byte(IDP, 16'h0400, 8'h02, a);
        check({7'h0, a}, 8'h01);
        t_lockquery(1'b0);
        write_byte(IDP, 16'h0001, 8'h00, a);
        check({7'h0, a}, 8'h00);
        read4(IDP, 16'h0000, {ID, 8'hff});
    endtask

    task automatic t_reset();
        m.start();
        m.send({MN, ~CE, 1'b0}, a);
        check({7'h0, a}, 8'h00);
        m.stop();
        i_rst = 1'b1;
        m.start();
        m.send({MN, CE, 1'b0}, a);
        check({7'h0, a}, 8'h00);
        m.stop();
        i_rst = 1'b0;
        m.tick(8);
        read4(MN, 16'h0105, 32'ha53cffff);
    endtask

    initial begin
        m.tick(20);
        i_rst = 1'b0;
        m.tick(10);
        t_delivered();
        t_group();
        t_lockquery(1'b1);
        t_lock();
        t_reset();
        close_out();
    end
endmodule // seec_top_test
